// ===== inc/adc_ctrl_pkg.sv
// constants, types and register map of the multiplexed converter control
// assumes one 10 MHz clock and a plain register port
// Contract
// - select exactly one of eight inputs
// - address binary, channel 0 to 7
// - capture address on load strobe rising
// - start rising clears result latch
// - start rising begins 32-clock sampling
// - new start before 64 clocks restarts
// - restarted conversion discards previous result
// - conversion lasts 57 to 74 clocks
// - done flag responds within 8 clocks
// - sampling phase then bit-decision phase
// - eight trials, then back to sampling (code goes to idle and waits for the next start)
// - first trial tests weight 128
// - above trip: set bit, remove weight
// - trials descend 64, 32 to LSB
// - result held in latch driving data outputs
package adc_ctrl_pkg;

  // ********************************
  // timing
  // ********************************
  localparam int SYS_CLK_HZ   = 10_000_000;
  localparam int CONV_CLK_HZ  = 640_000;
  localparam int CONV_DIV     = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int SAMPLE_TICKS = 32;
  localparam int TRIAL_TICKS  = 4;
  localparam int RESULT_W     = 8;
  localparam int CHAN_W       = 3;
  localparam int CHANNELS     = 8;

  // ********************************
  // register map
  // ********************************
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_MASK    = 4'h4;
  localparam logic [3:0] OFS_RESULT  = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hc;
  localparam int         EV_DONE     = 0;
  localparam int         EV_ABORT    = 1;
  localparam int         EV_W        = 2;
  localparam int         CTL_START   = 0;
  localparam int         RES_EOC     = 8;
  localparam int         RES_CHAN    = 16;
  localparam logic [EV_W-1:0]     MASK_RESET   = 2'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 8'h00;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_DECIDE = 3'b100
  } conv_state_t;

endpackage

// ===== design/rise_detect.sv
// rising-edge detector for one synchronous control input
// assumes the input is already synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module rise_detect (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      rise_out
);
  logic prev;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  assign rise_out = level_in & ~prev;
endmodule
`default_nettype wire

// ===== design/tick_divider.sv
// divider giving a one-cycle conversion-clock enable
// assumes a single free-running system clock
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 15
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] count;

  if (DIV < 2) begin : g_chk
    $error("tick_divider: DIV must be at least 2");
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (tick_out) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick_out = (count == CW'(DIV - 1));
endmodule
`default_nettype wire

// ===== design/adc_mux_sar_control.sv
// control of an eight-input multiplexer and 8-bit successive approximation
// assumes synchronous control inputs and an external comparator
`timescale 1ns/1ps
`default_nettype none
module adc_mux_sar_control
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  input  wire logic                clock_in,
  input  wire logic                arst_n_in,
  input  wire logic [CHAN_W-1:0]   addr_in,
  input  wire logic                addr_load_in,
  input  wire logic                start_in,
  input  wire logic                oe_in,
  input  wire logic                comp_above_in,
  input  wire reg_req_t            reg_req_in,
  output logic [31:0]              reg_rdata_out,
  output logic [CHANNELS-1:0]      mux_select_out,
  output logic                     sample_out,
  output logic [RESULT_W-1:0]      weights_out,
  output logic                     eoc_out,
  output logic [RESULT_W-1:0]      data_out,
  output logic                     data_oe_out,
  output logic                     irq_out
);

  // ********************************
  // elaboration checks
  // ********************************
  if (DIV < 2) begin : g_div_chk
    $error("adc_mux_sar_control: DIV must be at least 2");
  end
  // tick counter is six bits wide
  if (SAMPLE_TICKS > 64 || TRIAL_TICKS > 64) begin : g_tick_chk
    $error("adc_mux_sar_control: tick counts exceed the 6-bit counter");
  end
  if (CHANNELS != (1 << CHAN_W)) begin : g_chan_chk
    $error("adc_mux_sar_control: CHANNELS must match the address width");
  end
  // trial index is three bits, so exactly eight trials
  if (RESULT_W != 8) begin : g_res_chk
    $error("adc_mux_sar_control: RESULT_W must be 8");
  end

  // ********************************
  // reset release
  // ********************************
  logic [1:0] rst_pipe;
  logic       rst_n;

  // async assert, clocked release: no flop leaves reset on a runt edge
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ********************************
  // edges and conversion clock
  // ********************************
  logic load_rise;
  logic start_rise;
  logic tick;
  logic soft_start;
  logic start_evt;

  rise_detect u_load (
    .clk_in   (clock_in),
    .rst_n_in (rst_n),
    .level_in (addr_load_in),
    .rise_out (load_rise)
  );

  rise_detect u_start (
    .clk_in   (clock_in),
    .rst_n_in (rst_n),
    .level_in (start_in),
    .rise_out (start_rise)
  );

  tick_divider #(.DIV(DIV)) u_div (
    .clk_in   (clock_in),
    .rst_n_in (rst_n),
    .tick_out (tick)
  );

  // ********************************
  // channel address
  // ********************************
  logic [CHAN_W-1:0] channel;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      channel <= '0;
    end else if (load_rise) begin
      channel <= addr_in;
    end
  end

  // binary address, one switch closed at a time
  wire  [CHANNELS-1:0] addr_onehot = CHANNELS'(1) << addr_in;
  logic [CHANNELS-1:0] mux_sel;

  // select kept in a flop so the switch drive never glitches
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      mux_sel <= CHANNELS'(1);
    end else if (load_rise) begin
      mux_sel <= addr_onehot;
    end
  end

  assign mux_select_out = mux_sel;

  // ********************************
  // register port decode
  // ********************************
  wire wr_status  = reg_req_in.wr && (reg_req_in.addr == OFS_STATUS);
  wire wr_mask    = reg_req_in.wr && (reg_req_in.addr == OFS_MASK);
  wire wr_control = reg_req_in.wr && (reg_req_in.addr == OFS_CONTROL);

  assign soft_start = wr_control && reg_req_in.wdata[CTL_START];
  assign start_evt  = start_rise | soft_start;

  // ********************************
  // conversion sequencer
  // ********************************
  conv_state_t         state;
  conv_state_t         next_state;
  logic [5:0]          tick_cnt;
  logic [2:0]          trial_idx;
  logic [RESULT_W-1:0] bits;
  logic [RESULT_W-1:0] applied;
  logic [RESULT_W-1:0] latch;
  logic                eoc;

  wire                 sample_end = (state == ST_SAMPLE) && tick
                                    && (tick_cnt == 6'(SAMPLE_TICKS - 1));
  wire                 trial_end  = (state == ST_DECIDE) && tick
                                    && (tick_cnt == 6'(TRIAL_TICKS - 1));
  wire                 last_trial = trial_end && (trial_idx == 3'h0);
  wire [RESULT_W-1:0]  trial_w    = RESULT_W'(1) << trial_idx;
  wire                 busy       = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_SAMPLE: begin
        if (sample_end) begin
          next_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (last_trial) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (start_evt) begin
      next_state = ST_SAMPLE;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else if (start_evt || sample_end || trial_end) begin
      tick_cnt <= '0;
    end else if (busy && tick) begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      trial_idx <= 3'h7;
      bits      <= '0;
      applied   <= '0;
    end else if (start_evt || sample_end) begin
      trial_idx <= 3'h7;
      bits      <= '0;
      applied   <= '0;
    end else if (trial_end) begin
      trial_idx <= trial_idx - 3'h1;
      if (comp_above_in) begin
        bits <= bits | trial_w;
      end else begin
        applied <= applied | trial_w;
      end
    end
  end

  // trial weight rides on top of those kept from earlier trials
  assign weights_out = (state == ST_DECIDE) ? (applied | trial_w) : applied;
  assign sample_out  = (state == ST_SAMPLE);

  // ********************************
  // result latch and done flag
  // ********************************
  wire [RESULT_W-1:0] final_bits = comp_above_in ? (bits | trial_w) : bits;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      latch <= RESULT_RESET;
      eoc   <= 1'b0;
    end else if (start_evt) begin
      latch <= RESULT_RESET;
      eoc   <= 1'b0;
    end else if (last_trial) begin
      latch <= final_bits;
      eoc   <= 1'b1;
    end
  end

  assign eoc_out     = eoc;
  assign data_out    = latch;
  assign data_oe_out = oe_in;

  // ********************************
  // events, mask, interrupt
  // ********************************
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  wire  [EV_W-1:0] ev_set;
  wire  [EV_W-1:0] status_clr;

  assign status_clr = wr_status ? reg_req_in.wdata[EV_W-1:0] : {EV_W{1'b0}};

  assign ev_set[EV_DONE]  = last_trial && !start_evt;
  assign ev_set[EV_ABORT] = start_evt && busy;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask   <= MASK_RESET;
    end else begin
      // a new event wins over a clear in the same cycle
      status <= (status & ~status_clr) | ev_set;
      if (wr_mask) begin
        mask <= reg_req_in.wdata[EV_W-1:0];
      end
    end
  end

  assign irq_out = |(status & mask);

  // ********************************
  // read port
  // ********************************
  wire [31:0] rd_status = {{(32-EV_W){1'b0}}, status};
  wire [31:0] rd_mask   = {{(32-EV_W){1'b0}}, mask};
  wire [31:0] rd_ctl    = {31'h00000000, busy};
  logic [31:0] rd_result;
  logic [31:0] rd_word;

  // fields placed by their named positions, all other bits read zero
  always_comb begin
    rd_result                     = 32'h00000000;
    rd_result[RESULT_W-1:0]       = latch;
    rd_result[RES_EOC]            = eoc;
    rd_result[RES_CHAN +: CHAN_W] = channel;
  end

  always_comb begin
    if (reg_req_in.addr == OFS_STATUS) begin
      rd_word = rd_status;
    end else if (reg_req_in.addr == OFS_MASK) begin
      rd_word = rd_mask;
    end else if (reg_req_in.addr == OFS_RESULT) begin
      rd_word = rd_result;
    end else if (reg_req_in.addr == OFS_CONTROL) begin
      rd_word = rd_ctl;
    end else begin
      rd_word = 32'h00000000;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= rd_word;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ===== verif/adc_ctrl_sva.sv
// assertions on the port behaviour of the converter control
// assumes binding into adc_mux_sar_control
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva
  import adc_ctrl_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  input wire logic                clock_in,
  input wire logic                arst_n_in,
  input wire logic [CHAN_W-1:0]   addr_in,
  input wire logic                addr_load_in,
  input wire logic                start_in,
  input wire logic                oe_in,
  input wire logic [CHANNELS-1:0] mux_select_out,
  input wire logic                sample_out,
  input wire logic [RESULT_W-1:0] weights_out,
  input wire logic                eoc_out,
  input wire logic [RESULT_W-1:0] data_out,
  input wire logic                data_oe_out
);
  // ********
  // checks
  // ********
  logic start_d;
  logic eoc_d;
  logic rose_d;
  int   low_cnt;
  wire  start_rise = start_in && !start_d;
  wire  eoc_fall   = !eoc_out && eoc_d;
  // cycles since the last start; a pin start also drops eoc a cycle later
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_d <= 1'b0;
      eoc_d   <= 1'b0;
      rose_d  <= 1'b0;
      low_cnt <= 0;
    end else begin
      start_d <= start_in;
      eoc_d   <= eoc_out;
      rose_d  <= start_rise;
      if (start_rise) begin
        low_cnt <= 1;
      end else if (eoc_fall && !rose_d) begin
        low_cnt <= 2;
      end else begin
        low_cnt <= low_cnt + 1;
      end
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  property p_one; $onehot(mux_select_out); endproperty
  a_one: assert property (p_one) else $error("select not one-hot");
  property p_adr; $rose(addr_load_in) |=> mux_select_out == (8'h01 << $past(addr_in)); endproperty
  a_adr: assert property (p_adr) else $error("address capture");
  property p_clr; $rose(start_in) |=> !eoc_out && data_out == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("start clear");
  property p_smp; $rose(start_in) |=> sample_out; endproperty
  a_smp: assert property (p_smp) else $error("sampling start");
  property p_oe; data_oe_out == oe_in; endproperty
  a_oe: assert property (p_oe) else $error("output enable");
  property p_len; $rose(eoc_out) |-> low_cnt >= 57*DIV-2 && low_cnt <= 74*DIV+2; endproperty
  a_len: assert property (p_len) else $error("conversion length");
  property p_msb; $fell(sample_out) |-> weights_out == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("first trial weight");
  property p_hold; eoc_out && $past(eoc_out) |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("result not held");
endmodule
bind adc_mux_sar_control adc_ctrl_sva #(.DIV(DIV)) i_sva (
  .clock_in, .arst_n_in, .addr_in, .addr_load_in, .start_in, .oe_in, .mux_select_out,
  .sample_out, .weights_out, .eoc_out, .data_out, .data_oe_out);
`default_nettype wire

// ===== verif/analog_side.sv
// eight analog levels behind the multiplexer and the threshold detector
// assumes weights hold kept weights plus the trial weight as lowest bit
`timescale 1ns/1ps
`default_nettype none
module analog_side (
  input  wire logic [63:0] levels_in,
  input  wire logic [7:0]  mux_select_in,
  input  wire logic [7:0]  weights_in,
  output logic             comp_above_out
);
  logic [7:0] level;
  logic [7:0] trial;
  logic [7:0] guess;
  always_comb begin
    level = 8'h00;
    for (int i = 0; i < 8; i++) if (mux_select_in[i]) level = levels_in[i*8 +: 8];
    trial = weights_in & (~weights_in + 8'h01);
    guess = (~weights_in & ~((trial << 1) - 8'h01)) | trial;
    comp_above_out = (trial != 8'h00) && (level >= guess);
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the converter control
// assumes analog_side as comparator and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb
  import adc_ctrl_pkg::*;
;
  localparam int D = 2;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic        ald = 1'b0;
  logic        start = 1'b0;
  logic        oe = 1'b0;
  logic        comp;
  reg_req_t    req = '0;
  logic [31:0] rdata;
  logic [7:0]  msel, wts, dout;
  logic        eoc, smp, doe, irq;
  logic [63:0] levels = 64'hc3aa5501_7f80ff00;
  int          mismatches = 0;
  int          cmp_count = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  adc_mux_sar_control #(.DIV(D)) i_dut (.clock_in(clk), .arst_n_in(arst_n), .addr_in(addr),
    .addr_load_in(ald), .start_in(start), .oe_in(oe), .comp_above_in(comp), .reg_req_in(req),
    .reg_rdata_out(rdata), .mux_select_out(msel), .sample_out(smp), .weights_out(wts),
    .eoc_out(eoc), .data_out(dout), .data_oe_out(doe), .irq_out(irq));
  analog_side i_far (.levels_in(levels), .mux_select_in(msel), .weights_in(wts),
    .comp_above_out(comp));
  // ********
  // tasks
  // ********
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic load_addr(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    ald <= 1'b1;
    oe <= a[0];
    @(posedge clk);
    ald <= 1'b0;
    #1 chk("mux", 8'h01 << a, msel);
  endtask
  task automatic pulse_start();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1 chk("eoc low", 32'h00000000, eoc);
    chk("latch clear", 0, dout);
    chk("sampling", 1, smp);
  endtask
  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 1000) begin
      mismatches++;
      finish_test();
    end
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_channels();
    int n;
    for (int ch = 0; ch < 8; ch++) begin
      load_addr(ch[2:0]);
      if (ch == 7) begin
        reg_wr(OFS_CONTROL, 32'h1);
        #1 chk("soft start eoc", 32'h00000000, eoc);
        chk("soft start latch", 32'h00000000, dout);
      end else begin
        pulse_start();
      end
      wait_eoc(n);
      chk("time", 1, n >= 57*D-3 && n <= 74*D+2);
      chk("result", levels[ch*8 +: 8], dout);
      chk("oe", ch[0], doe);
      reg_rd(OFS_RESULT, {13'h0, ch[2:0], 7'h0, 1'b1, levels[ch*8 +: 8]}, "res reg");
    end
    @(posedge clk);
    addr <= 3'h0;
    @(posedge clk);
    #1 chk("addr hold", 8'h80, msel);
    $display("test channels done");
  endtask
  task automatic t_abort();
    int n;
    load_addr(3'h5);
    pulse_start();
    repeat (40 * D) @(posedge clk);
    pulse_start();
    reg_rd(OFS_CONTROL, 32'h00000001, "busy");
    wait_eoc(n);
    chk("restart time", 1, n >= 57*D-3 && n <= 74*D+2);
    chk("restart result", 8'h55, dout);
    reg_rd(OFS_STATUS, 32'h3, "status");
    reg_rd(4'h2, 32'h0, "unmapped");
    chk("irq masked", 0, irq);
    reg_wr(OFS_MASK, 32'h2);
    #1 chk("irq on", 1, irq);
    reg_wr(OFS_STATUS, 32'h2);
    #1 chk("irq off", 0, irq);
    reg_rd(OFS_STATUS, 32'h1, "status w1c");
    reg_rd(OFS_MASK, 32'h2, "mask");
    reg_rd(OFS_CONTROL, 32'h00000000, "idle");
    $display("test abort done");
  endtask
  // done looped back to start, as a controller would wire it
  task automatic t_free();
    int n;
    load_addr(3'h6);
    pulse_start();
    repeat (2) begin
      wait_eoc(n);
      chk("free result", {24'h000000, levels[6*8 +: 8]}, dout);
      @(posedge clk);
      start <= eoc;
      @(posedge clk);
      start <= 1'b0;
      #1 chk("free restart", 32'h00000000, eoc);
    end
    wait_eoc(n);
    chk("free time", 1, n >= 57*D-3 && n <= 74*D+2);
    chk("free last", {24'h000000, levels[6*8 +: 8]}, dout);
    $display("test free run done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(OFS_MASK, 32'h0, "mask reset");
    t_channels();
    t_abort();
    t_free();
    finish_test();
  end
endmodule
`default_nettype wire
